// file: hdl/scma_top.v
// Connection and data memory access control for a 256 x 256 slot switch,
// with its 256-word connection memory and a 256-word data memory store.
// Assumes one 100 MHz clock, synchronous active-low reset, AXI4-Lite master.
// Software must poll the busy bit before it reads the fetched word.
`timescale 1ns/1ps
`include "scma_map.vh"

// How it works
// R1 - Writing the destination byte of the access register launches a memory access.
// R2 - Access register is 16 bits: mode upper byte, destination lower, reset 0800.
// R3 - Connection target: five slot bits pick slot 0-31, three mux bits pick 0-7.
// R4 - At 4 Mbit/s, mux bits 7 and 6 pick pin 0, 2, 4 or 6.
// R5 - At 4 Mbit/s output slot is slot bits above mux bit 5, giving 0-63.
// R6 - At 4 Mbit/s input slot is source slot bits above source bit 5, 0-63.
// R7 - At 2 Mbit/s mux bit 5 picks even or odd multiplex, not slot half.
// R8 - Fast clock select: 8192 kHz bit clock, sampling at three quarters bit.
// R9 - Slow clock: 4096 kHz, 4 Mbit/s sampled mid-bit, 2 Mbit/s at three quarters.
// R10 - With a cyclic bit set the destination byte tracks the current address.
// R11 - Data memory target allows reads only; a write request is served as a read.
// R12 - Read bit one reads the selected memory, zero writes connection memory.
// R13 - Two-way bit writes forward and reverse entries; loopback only on forward.
// R14 - Full cyclic write ignores two-way, fills from destination up to FF.
// R15 - Full cyclic read: each fetched-word register read loads the next location up to FF.
// R16 - Limited cyclic write fills the chosen multiplex from given slot to 1F.
// R17 - Limited cyclic read: each data read loads next slot through 1F.
// R18 - Transparent write ignores source and two-way, maps slot i mux j to itself.
// R19 - Transparent writes one, up to 32 or up to 256 entries by cyclic bits.
// R20 - Without transparent or cyclic bits, writes follow the two-way bit; reads ignore it.
// R21 - Cyclic write steps address by one per write, stops after the last.
module scma_top (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Switch write port toward the data memory
   input  wire        dm_wr_en,
   input  wire [7:0]  dm_wr_addr,
   input  wire [7:0]  dm_wr_data,
   // Rate input, and mode and decode outputs to the switching fabric
   input  wire        mux_is_4m,
   output reg         fast_bit_clock,
   output reg         sample_three_quarter,
   output reg  [2:0]  out_pin_sel,
   output reg  [5:0]  out_slot_num,
   output reg  [5:0]  in_slot_num,
   output reg  [2:0]  in_pin_sel
);

   // =======================================================================
   // State encodings and storage
   // IDLE waits for a launch, or for a fetched-word read inside a read run.
   // WRITE stores one connection entry per cycle, stepping in cyclic runs.
   // REV stores the reverse entry of a plain two-way write, in one cycle.
   // READ loads one word into the fetched-word register, in one cycle.
   localparam [3:0] ST_IDLE  = 4'b0001;
   localparam [3:0] ST_WRITE = 4'b0010;
   localparam [3:0] ST_REV   = 4'b0100;
   localparam [3:0] ST_READ  = 4'b1000;

   // Entries are 16 bits wide; the data memory keeps one byte per input slot.
   // Neither array is reset, so software must write before it trusts a read.
   reg  [15:0] conn_mem [0:255];
   reg  [7:0]  data_mem [0:255];

   // Software visible registers
   reg  [15:0] access_r;
   reg  [15:0] data_r;
   reg  [15:0] cfg_r;
   reg  [15:0] memdata_r;
   // Sequencer state, run pointer and run end
   reg  [3:0]  state_r;
   reg  [7:0]  cur_addr_r;
   reg  [7:0]  last_addr_r;
   reg         busy_r;
   reg         aw_hold_r;
   reg         w_hold_r;
   // Captured write halves, held until both are present
   reg  [7:0]  aw_addr_r;
   reg  [31:0] w_data_r;
   reg  [3:0]  w_strb_r;

   // Mode bits come from the live register, whose mode half a run never alters
   wire        target_conn = access_r[`SCMA_B_TARGET];
   wire        mode_read   = access_r[`SCMA_B_READ];
   wire        mode_full   = access_r[`SCMA_B_FULL];
   wire        mode_lim    = access_r[`SCMA_B_LIMITED];
   wire        mode_transp = access_r[`SCMA_B_TRANSP];
   wire        mode_twoway = access_r[`SCMA_B_TWOWAY];
   wire        cyclic      = mode_full | mode_lim;

   // Write accepted when both address and data are held
   // The commit edge updates the register and raises the response together;
   // strobe bit 0 alone decides whether an access write launches a run.
   wire        wr_fire  = aw_hold_r & w_hold_r & ~s_axi_bvalid;
   wire        wr_acc   = wr_fire & (aw_addr_r == `SCMA_ADDR_ACCESS);
   wire        wr_dat   = wr_fire & (aw_addr_r == `SCMA_ADDR_DATA);
   wire        wr_cfg   = wr_fire & (aw_addr_r == `SCMA_ADDR_CONFIG);
   wire        wr_known = wr_acc | wr_dat | wr_cfg;
   wire        launch   = wr_acc & w_strb_r[0];                        // R1
   wire        rd_fire  = s_axi_arvalid & s_axi_arready;
   wire        rd_mdat  = rd_fire & (s_axi_araddr == `SCMA_ADDR_MEMDATA);

   // Merged access value after byte strobes
   // The two unused top bits are masked so they always read back as zero
   wire [15:0] acc_new = {w_strb_r[1] ? w_data_r[15:8] : access_r[15:8],
                          w_strb_r[0] ? w_data_r[7:0]  : access_r[7:0]} & `SCMA_ACCESS_MASK; // R2
   wire [15:0] dat_new = {w_strb_r[1] ? w_data_r[15:8] : data_r[15:8],
                          w_strb_r[0] ? w_data_r[7:0]  : data_r[7:0]};

   // Source fields sit in the low byte of the data register
   wire [7:0]  src_addr = data_r[7:0];
   // Transparent entry names the destination itself as source
   wire [15:0] fwd_word = mode_transp ? {data_r[15:8], cur_addr_r} : data_r;        // R18
   // Bit 15 of the data register is the forward entry's loopback flag;
   // the reverse entry never loops back, so that bit is cleared there
   wire [15:0] rev_word = {data_r[15:8], cur_addr_r} & ~(16'h0001 << `SCMA_B_LOOP); // R13

   // =======================================================================
   // Write channel: capture address and data in either order
   // Each ready pulses for one cycle and returns two cycles later, so a master
   // that holds valid is taken within two cycles. Readies stay low while the
   // engine runs, which keeps a new access from landing mid-run; a write whose
   // halves are already held still completes and is answered.
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r     <= 1'b0;
         w_hold_r      <= 1'b0;
         aw_addr_r     <= 8'h00;
         w_data_r      <= 32'h0000_0000;
         w_strb_r      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SCMA_RESP_OKAY;
      end else begin
         // Readies pulse, then drop while a half is held or the engine runs
         s_axi_awready <= ~aw_hold_r & ~s_axi_awready & ~busy_r;
         s_axi_wready  <= ~w_hold_r & ~s_axi_wready & ~busy_r;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         // Unknown or read-only offsets are answered SLVERR and change nothing
         if (wr_fire) begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? `SCMA_RESP_OKAY : `SCMA_RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // =======================================================================
   // Read channel; one cycle answer, refused while an access is running
   // Read data are captured on the handshake edge, so a read of the fetched
   // word returns the entry fetched before; the advance that the same read
   // starts shows up on the following read. Unmapped offsets answer SLVERR.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `SCMA_RESP_OKAY;
      end else begin
         // Ready waits until the previous answer has been taken
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & ~busy_r;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `SCMA_RESP_OKAY;
            case (s_axi_araddr)
               `SCMA_ADDR_ACCESS:  s_axi_rdata <= {16'h0000, access_r};
               `SCMA_ADDR_DATA:    s_axi_rdata <= {16'h0000, data_r};
               `SCMA_ADDR_STATUS:  s_axi_rdata <= {16'h0000, 7'h00, busy_r, cur_addr_r};
               `SCMA_ADDR_CONFIG:  s_axi_rdata <= {16'h0000, cfg_r};
               `SCMA_ADDR_MEMDATA: s_axi_rdata <= {16'h0000, memdata_r};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `SCMA_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // =======================================================================
   // Data memory fill from the switch side
   // The switch writes one byte per cycle with no handshake; a fetch of the
   // same slot in the same cycle returns the old byte, which is harmless
   // because received bytes are refreshed every frame.
   always @(posedge aclk) begin
      if (dm_wr_en)
         data_mem[dm_wr_addr] <= dm_wr_data;
   end

   // =======================================================================
   // Access engine: registers, sequencer and connection memory
   // Cyclic write runs hold the bus off so the tracked address stays coherent.
   // Trade-off: a full run of 256 entries blocks the bus for 256 cycles, in
   // exchange for a sequencer with no second write port or queue.
   // A launch uses the merged value, since access_r takes it on this edge too.
   always @(posedge aclk) begin
      if (!aresetn) begin
         access_r    <= `SCMA_ACCESS_RST;                               // R2
         data_r      <= `SCMA_DATA_RST;
         cfg_r       <= `SCMA_CFG_RST;
         memdata_r   <= `SCMA_ZERO16;
         state_r     <= ST_IDLE;
         cur_addr_r  <= 8'h00;
         last_addr_r <= 8'h00;
         busy_r      <= 1'b0;
      end else begin
         // Register writes land on the commit edge
         if (wr_dat)
            data_r <= dat_new;
         if (wr_cfg)
            cfg_r <= {w_strb_r[1] ? w_data_r[15:8] : cfg_r[15:8],
                      w_strb_r[0] ? w_data_r[7:0]  : cfg_r[7:0]};
         if (wr_acc)
            access_r <= acc_new;
         case (state_r)
            ST_IDLE: begin
               // A launch takes priority over a fetched-word read in the same cycle
               if (launch) begin
                  busy_r     <= 1'b1;
                  cur_addr_r <= acc_new[7:0];
                  // Limited runs end at slot 1F of the same multiplex
                  last_addr_r <= acc_new[`SCMA_B_LIMITED] ?
                                 (acc_new[7:0] | `SCMA_SLOT_MASK) :                // R16
                                 `SCMA_LAST_ADDR;                                  // R14
                  // Data memory is read only, so a write request there is served as a fetch
                  if (acc_new[`SCMA_B_READ] | ~acc_new[`SCMA_B_TARGET])
                     state_r <= ST_READ;                                           // R11 R12
                  else
                     state_r <= ST_WRITE;                                          // R12
               end else if (rd_mdat & cyclic & target_conn & mode_read &
                            (cur_addr_r != last_addr_r)) begin
                  // Reading the fetched word advances to the next entry
                  busy_r     <= 1'b1;
                  cur_addr_r <= cur_addr_r + 8'h01;                                // R15 R17
                  access_r[7:0] <= cur_addr_r + 8'h01;                             // R10
                  state_r    <= ST_READ;
               end
            end
            ST_READ: begin
               // The target bit picks the memory; data memory bytes are zero-extended
               memdata_r <= target_conn ? conn_mem[cur_addr_r] :
                            {8'h00, data_mem[cur_addr_r]};                         // R11
               busy_r    <= 1'b0;
               state_r   <= ST_IDLE;
            end
            ST_WRITE: begin
               // The reverse entry belongs to plain single writes only; cyclic
               // and transparent runs ignore the two-way bit
               conn_mem[cur_addr_r] <= fwd_word;                                   // R13
               if (~cyclic & ~mode_transp & mode_twoway) begin
                  state_r <= ST_REV;                                               // R20
               end else if (cyclic & (cur_addr_r != last_addr_r)) begin
                  cur_addr_r    <= cur_addr_r + 8'h01;                             // R21
                  access_r[7:0] <= cur_addr_r + 8'h01;                             // R10
               end else begin
                  busy_r  <= 1'b0;                                                 // R19
                  state_r <= ST_IDLE;
               end
            end
            ST_REV: begin
               // Reverse entry at the source location, loopback dropped
               conn_mem[src_addr] <= rev_word;                                     // R13
               busy_r  <= 1'b0;
               state_r <= ST_IDLE;
            end
            default: begin
               // An illegal code returns to idle and frees the bus
               busy_r  <= 1'b0;
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // =======================================================================
   // Slot and pin decode toward the fabric
   // The decode lags the registers by one cycle, well inside any slot time.
   // One rate input serves both directions, so a 4 Mbit/s input pin paired
   // with a 2 Mbit/s output pin cannot be shown at once; this is a limitation.
   // Reset leaves the sampling point at three quarters, the slow 2 Mbit/s case.
   always @(posedge aclk) begin
      if (!aresetn) begin
         fast_bit_clock       <= 1'b0;
         sample_three_quarter <= 1'b1;
         out_pin_sel          <= 3'h0;
         out_slot_num         <= 6'h00;
         in_slot_num          <= 6'h00;
         in_pin_sel           <= 3'h0;
      end else begin
         fast_bit_clock <= cfg_r[`SCMA_B_FASTCLK];                                 // R8 R9
         sample_three_quarter <= cfg_r[`SCMA_B_FASTCLK] | ~mux_is_4m;              // R8 R9
         // At 4 Mbit/s mux bit 5 becomes the slot LSB and pins step by two
         if (mux_is_4m) begin
            out_pin_sel  <= {access_r[7:6], 1'b0};                                 // R4
            out_slot_num <= {access_r[4:0], access_r[`SCMA_B_MUX0]};               // R5
            in_pin_sel   <= {data_r[7:6], 1'b0};                                   // R4
            in_slot_num  <= {data_r[4:0], data_r[`SCMA_B_MUX0]};                   // R6
         end else begin
            out_pin_sel  <= access_r[7:5];                                         // R3 R7
            out_slot_num <= {1'b0, access_r[4:0]};                                 // R3
            in_pin_sel   <= data_r[7:5];                                           // R7
            in_slot_num  <= {1'b0, data_r[4:0]};
         end
      end
   end

endmodule // scma_top

// file: hdl/scma_map.vh
// Register map, field positions and reset values for the
// connection memory access block. Assumes a 32-bit AXI4-Lite register bus.
`ifndef SCMA_MAP_VH
`define SCMA_MAP_VH
// ==========================================================================
// Register byte addresses
`define SCMA_ADDR_ACCESS   8'h10
`define SCMA_ADDR_DATA     8'h14
`define SCMA_ADDR_STATUS   8'h18
`define SCMA_ADDR_CONFIG   8'h1C
`define SCMA_ADDR_MEMDATA  8'h20
// ==========================================================================
// Access register fields and reset
`define SCMA_ACCESS_RST    16'h0800
`define SCMA_ACCESS_MASK   16'h3FFF
`define SCMA_B_READ        8
`define SCMA_B_TARGET      9
`define SCMA_B_TWOWAY      10
`define SCMA_B_FULL        11
`define SCMA_B_LIMITED     12
`define SCMA_B_TRANSP      13
`define SCMA_B_MUX0        5
`define SCMA_B_LOOP        15
// ==========================================================================
// Other fields
`define SCMA_B_FASTCLK     0
`define SCMA_CFG_RST       16'h0000
`define SCMA_DATA_RST      16'h0000
`define SCMA_LAST_ADDR     8'hFF
`define SCMA_LAST_SLOT     5'h1F
`define SCMA_SLOT_MASK     8'h1F
`define SCMA_ZERO16        16'h0000
// ==========================================================================
// AXI responses
`define SCMA_RESP_OKAY     2'b00
`define SCMA_RESP_SLVERR   2'b10
`endif

// file: verif/scma_top_assertions.sv
// Checker for the connection memory access block: bus answers, clock mode
// outputs and 4 Mbit/s output pin decode. Sees only the top ports; bound at the foot.
`timescale 1ns/1ps
module scma_chk (
   // Clock and reset
   input logic       aclk,
   input logic       aresetn,
   // Bus handshakes
   input logic       s_axi_awvalid,
   input logic       s_axi_awready,
   input logic       s_axi_wvalid,
   input logic       s_axi_wready,
   input logic       s_axi_bvalid,
   input logic       s_axi_bready,
   input logic       s_axi_arvalid,
   input logic       s_axi_arready,
   input logic       s_axi_rvalid,
   input logic       s_axi_rready,
   // Rate and decode
   input logic       mux_is_4m,
   input logic       fast_bit_clock,
   input logic       sample_three_quarter,
   input logic [2:0] out_pin_sel
);
   // ======
   // One clock domain, so one clocking and one reset for all
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Both halves taken: they commit on the next edge, the answer shows one edge later
   property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid; endproperty
   a_bans: assert property (p_bans) else $error("write not answered");
   property p_bone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_bone: assert property (p_bone) else $error("write answered twice");
   property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rans: assert property (p_rans) else $error("read not answered");
   property p_rone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_rone: assert property (p_rone) else $error("read answered twice");
   // Mode outputs may lag one edge, so each cause is held over two edges
   property p_fast; fast_bit_clock && $past(fast_bit_clock) |-> sample_three_quarter; endproperty
   a_fast: assert property (p_fast) else $error("fast clock not sampling late");
   property p_slow4; $past(aresetn) && mux_is_4m && $past(mux_is_4m) && !fast_bit_clock
      && !$past(fast_bit_clock) |-> !sample_three_quarter; endproperty
   a_slow4: assert property (p_slow4) else $error("slow 4M not sampling mid-bit");
   property p_slow2; $past(aresetn) && !mux_is_4m && !$past(mux_is_4m) |-> sample_three_quarter; endproperty
   a_slow2: assert property (p_slow2) else $error("2M not sampling late");
   property p_pin4; $past(aresetn) && mux_is_4m && $past(mux_is_4m) |-> !out_pin_sel[0]; endproperty
   a_pin4: assert property (p_pin4) else $error("4M pin not even");
   // Main scenarios reached
   c_write: cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);
   c_fast: cover property (fast_bit_clock && sample_three_quarter);
   c_slow4: cover property (mux_is_4m && !fast_bit_clock && !sample_three_quarter);
endmodule // scma_chk

bind scma_top scma_chk scma_chk_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .mux_is_4m, .fast_bit_clock, .sample_three_quarter, .out_pin_sel);

// file: verif/scma_top_bench.sv
// Self-checking bench for the connection memory access block; drives the
// register bus, the data memory write port and the rate input itself.
`timescale 1ns/1ps
`include "scma_map.vh"
module scma_top_bench;
   // ======
   // Design connections and bench state
   logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, dm_wr_en = 0, mux_is_4m = 0, m;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, dm_wr_addr = '0, dm_wr_data = '0, a;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdv;
   logic [3:0]  s_axi_wstrb = '0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        fast_bit_clock, sample_three_quarter;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic [2:0]  out_pin_sel, in_pin_sel;
   logic [5:0]  out_slot_num, in_slot_num;
   logic [15:0] d;
   int          mismatches = 0, n_checks = 0, i;
   always #5 aclk = ~aclk;
   scma_top scma_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .dm_wr_en, .dm_wr_addr, .dm_wr_data, .mux_is_4m, .fast_bit_clock,
      .sample_three_quarter, .out_pin_sel, .out_slot_num, .in_slot_num, .in_pin_sel);
   // ======
   // Bus tasks: each channel released on the edge its ready is seen
   task chk(input [31:0] g, input [31:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task wr(input [7:0] ad, input [15:0] v);
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= {16'h0000, v};
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rd(input [7:0] ad);
      @(posedge aclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rdv = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Poll busy; leaves the status word, current address in the low byte
   task idle;
      do rd(8'h18); while (rdv[8] !== 1'b0);
   endtask
   task acc(input [15:0] v);
      wr(8'h10, v);
      idle;
   endtask
   task sw(input [7:0] x, input [15:0] v);
      wr(8'h14, v);
      acc({8'h02, x});
   endtask
   task rb(input [7:0] x);
      acc({8'h03, x});
      rd(8'h20);
   endtask
   // Expected pin and slot: 4M takes bit 5 as slot LSB, 2M as mux LSB
   function automatic [8:0] dec(input [7:0] x, input q);
      dec = q ? {x[7:6], 1'b0, x[4:0], x[5]} : {x[7:5], 1'b0, x[4:0]};
   endfunction
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #1_000_000;
      mismatches++;
      close_out;
   end
   // ======
   // Main sequence
   initial begin
      rdv = $urandom(74116);
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h10);
      chk(rdv, 32'h0000_0800);
      rd(8'h30);
      chk({rr, rdv[29:0]}, {`SCMA_RESP_SLVERR, 30'h0000_0000});
      wr(8'h18, 16'h0000);
      chk(rr, `SCMA_RESP_SLVERR);
      wr(8'h1C, 16'h0001);
      chk(rr, `SCMA_RESP_OKAY);
      mux_is_4m <= 1'b1;
      repeat (3) @(posedge aclk);
      chk({fast_bit_clock, sample_three_quarter}, 2'b11);
      wr(8'h1C, 16'h0000);
      repeat (3) @(posedge aclk);
      chk({fast_bit_clock, sample_three_quarter}, 2'b00);
      for (i = 0; i < 4; i++) begin
         a = 8'($urandom);
         d = 16'($urandom);
         m = 1'($urandom);
         mux_is_4m <= m;
         sw(a, d);
         rb(a);
         chk(rdv, {16'h0000, d});
         chk({out_pin_sel, out_slot_num}, dec(a, m));
         chk({in_pin_sel, in_slot_num}, dec(d[7:0], m));
         chk({fast_bit_clock, sample_three_quarter}, {1'b0, !m});
      end
      wr(8'h14, 16'hAA31);
      acc(16'h0647);
      rb(8'h47);
      chk(rdv, 32'h0000_AA31);
      rb(8'h31);
      chk(rdv, 32'h0000_2A47);
      // Guard words around the block fill show a reverse write or overrun
      sw(8'hFB, 16'h0055);
      sw(8'h00, 16'h0055);
      wr(8'h14, 16'h3CFB);
      acc(16'h0EFC);
      for (i = 251; i < 257; i++) begin
         rb(i[7:0]);
         chk(rdv, (i == 251 || i == 256) ? 32'h0000_0055 : 32'h0000_3CFB);
      end
      sw(8'hFE, 16'h0077);
      acc(16'h0BFD);
      for (i = 0; i < 3; i++) begin
         idle;
         chk(rdv[7:0], 8'hFD + i);
         rd(8'h20);
         chk(rdv, (i == 1) ? 32'h0000_0077 : 32'h0000_3CFB);
      end
      sw(8'hBC, 16'h0011);
      sw(8'hC0, 16'h0011);
      wr(8'h14, 16'h0123);
      acc(16'h12BD);
      for (i = 188; i < 193; i++) begin
         rb(i[7:0]);
         chk(rdv, (i == 188 || i == 192) ? 32'h0000_0011 : 32'h0000_0123);
      end
      // Limited read run from slot 1E must stop at slot 1F, never reach C0
      sw(8'hBF, 16'h0044);
      acc(16'h13BE);
      for (i = 0; i < 3; i++) begin
         idle;
         chk(rdv[7:0], (i == 0) ? 8'hBE : 8'hBF);
         rd(8'h20);
         chk(rdv, (i == 0) ? 32'h0000_0123 : 32'h0000_0044);
      end
      wr(8'h14, 16'h0000);
      acc(16'h365E);
      for (i = 94; i < 96; i++) begin
         rb(i[7:0]);
         chk(rdv[7:0], i[7:0]);
      end
      @(posedge aclk);
      dm_wr_en <= 1'b1;
      dm_wr_addr <= 8'h42;
      dm_wr_data <= 8'h9C;
      @(posedge aclk);
      dm_wr_en <= 1'b0;
      sw(8'h42, 16'h0099);
      acc(16'h0042);
      rb(8'h42);
      chk(rdv, 32'h0000_0099);
      acc(16'h0142);
      rd(8'h20);
      chk(rdv, 32'h0000_009C);
      close_out;
   end
endmodule // scma_top_bench
